// ### include/pcs_tx_consts.svh
// Purpose: constants of the 81-bit block transmit encoder
// Assumes: 10 MHz system clock
// Notes:   offsets are byte addresses on the register bus
`ifndef PCS_TX_CONSTS_SVH
`define PCS_TX_CONSTS_SVH

// ****************************************
// register map
// ****************************************
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_BLOCK_COUNT  8'h08
`define REG_MAINT        8'h0C
`define REG_FRAME_COUNT  8'h10
`define CTRL_RESET_BIT   0
`define CTRL_EEE_BIT     1
`define CTRL_RESET_VAL   32'h0000_0000
`define MAINT_RESET_VAL  9'h000

// ****************************************
// block geometry
// ****************************************
`define OCTETS_PER_BLOCK 4'hA
`define BLOCK_BITS       81
`define BLOCKS_PER_FRAME 6'h2D
`define MAINT_BITS       9

// ****************************************
// control codes, bit i lands on octet bit 5+i
// ****************************************
`define CODE_IDLE_NREADY 3'h0
`define CODE_IDLE_READY  3'h2
`define CODE_TX_ERROR    3'h4
`define CODE_LPI         3'h5
`define LPI_REQ_TXD      8'h01

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS    100
`define SYM_PERIOD_NUM   4
`define SYM_PERIOD_DEN   3
`define SYM_CYCLES_RAW   (`SYM_PERIOD_NUM / (`SYM_PERIOD_DEN * `CLK_PERIOD_NS))
`define SYM_CYCLES       ((`SYM_CYCLES_RAW < 1) ? 1 : `SYM_CYCLES_RAW)
`define INFO_INTERVAL    16'h0200
`define INFO_LEN         5'h10
`define INFO_HEADER      15'h5A3C
`define TRAIN_SEED       15'h0001

`endif

// ### include/pcs_tx_pkg.sv
// Purpose: types of the 81-bit block transmit encoder
// Assumes: nothing beyond the constants header
// Notes:   carriers are packed structs
`default_nettype none
package pcs_tx_pkg;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] txd;
    logic       tx_en;
    logic       tx_er;
  } gmii_tx_t;

  typedef struct packed {
    logic [80:0] bits;
    logic [5:0]  index;
  } coded_block_t;

  // three-level symbol, two's complement
  typedef enum logic [1:0] {
    SYM_ZERO  = 2'b00,
    SYM_PLUS  = 2'b01,
    SYM_MINUS = 2'b11
  } symbol_t;

  typedef enum logic [3:0] {
    ST_RESET = 4'b0001,
    ST_TRAIN = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_LPI   = 4'b1000
  } tx_state_t;

endpackage : pcs_tx_pkg
`default_nettype wire

// ### rtl/training_sequence_gen.sv
// Purpose: training symbol source with periodic startup field
// Assumes: step pulses once per symbol period
// Notes:   emits only plus one and minus one
`include "pcs_tx_consts.svh"
`default_nettype none
module training_sequence_gen (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               clear,
  input  wire logic               step,
  input  wire logic               loc_rcvr_status,
  output pcs_tx_pkg::symbol_t     symbol,
  output logic                    info_active
);
  import pcs_tx_pkg::*;

  logic [14:0] lfsr;
  logic [15:0] interval_cnt;
  logic [4:0]  info_pos;
  logic [15:0] info_word;
  logic        next_bit;

  // ****************************************
  // sequence state
  // ****************************************
  // startup field: fixed header then local receiver status
  assign info_word = {loc_rcvr_status, `INFO_HEADER};

  // field bit while inserting, scrambled bit otherwise
  assign next_bit = info_active ? info_word[info_pos[3:0]] : lfsr[14];

  // free-running sequence and insertion timer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr         <= `TRAIN_SEED;
      interval_cnt <= 16'h0000;
      info_pos     <= 5'h00;
      info_active  <= 1'b0;
    end else if (clear) begin
      lfsr         <= `TRAIN_SEED;
      interval_cnt <= 16'h0000;
      info_pos     <= 5'h00;
      info_active  <= 1'b0;
    end else if (step) begin
      lfsr <= {lfsr[13:0], lfsr[14] ^ lfsr[13]};
      if (info_active) begin
        info_pos <= info_pos + 5'h01;
        if (info_pos == `INFO_LEN - 5'h01) begin
          info_active <= 1'b0;
        end
      end else if (interval_cnt == `INFO_INTERVAL - 16'h0001) begin
        interval_cnt <= 16'h0000;
        info_pos     <= 5'h00;
        info_active  <= 1'b1;
      end else begin
        interval_cnt <= interval_cnt + 16'h0001;
      end
    end
  end

  // only the two outer levels are ever produced
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      symbol <= SYM_MINUS;
    end else if (step) begin
      symbol <= next_bit ? SYM_PLUS : SYM_MINUS;
    end
  end

endmodule : training_sequence_gen
`default_nettype wire

// ### rtl/pcs_81b_block_transmit_encoder.sv
// Purpose: transmit side of the coding sublayer, octets to 81-bit blocks
// Assumes: transmit octets synchronous to sys_clk, one per cycle
// Notes:   frame coding, scrambling and level mapping sit downstream
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
`include "pcs_tx_consts.svh"
`default_nettype none
module pcs_81b_block_transmit_encoder (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [31:0]            wb_dat_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic                   wb_we_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  output logic [31:0]                 wb_dat_o,
  output logic                        wb_ack_o,
  input  wire pcs_tx_pkg::gmii_tx_t   gmii_tx,
  input  wire logic                   pma_transmit_mode_indication,
  input  wire logic                   loc_rcvr_status,
  input  wire logic                   loc_data_ready,
  output pcs_tx_pkg::coded_block_t    coded_block,
  output logic                        block_valid,
  output logic [8:0]                  maintenance_symbol,
  output logic                        maintenance_valid,
  output pcs_tx_pkg::symbol_t         pma_symbol,
  output logic                        pma_symbol_transfer_request,
  output logic                        startup_information_field,
  output logic                        tx_lpi_active
);
  import pcs_tx_pkg::*;

  // ****************************************
  // block coding
  // ****************************************
  // octet n sits in bits 8n+7..8n, bit k of the octet is its k-th sent bit
  function automatic logic [80:0] encode_block(input logic [79:0] td,
                                               input logic [9:0]  tc);
    logic [80:0] b;
    logic        or_n;
    logic        tc_prev;
    logic [3:0]  pos;
    logic [3:0]  cnt;
    logic [4:0]  nxt;
    b = 81'h0;
    b[0] = |tc;
    for (int n = 0; n < 10; n++) begin
      or_n = 1'b0;
      pos  = 4'hF;
      cnt  = 4'h0;
      for (int m = 9; m >= n; m--) begin
        if (tc[m]) begin
          or_n = 1'b1;
          pos  = 4'(m);
          cnt  = cnt + 4'h1;
        end
      end
      nxt     = {(cnt != 4'h1), pos};
      tc_prev = (n == 0) ? 1'b1 : tc[n-1];
      for (int k = 0; k < 5; k++) begin
        if (!or_n) begin
          b[8*n+1+k] = td[8*n+k];
        end else if (tc_prev) begin
          b[8*n+1+k] = nxt[k];
        end else begin
          b[8*n+1+k] = td[8*(n-1)+3+k];
        end
      end
      for (int k = 0; k < 3; k++) begin
        if (!or_n || tc[n]) begin
          b[8*n+6+k] = td[8*n+5+k];
        end else begin
          b[8*n+6+k] = td[8*n+k];
        end
      end
    end
    return b;
  endfunction : encode_block

  // octet as stored: control code in bits 7..5, low bits left at zero
  function automatic logic [7:0] control_octet(input logic [2:0] code);
    return {code, 5'h00};
  endfunction : control_octet

  // ****************************************
  // declarations
  // ****************************************
  tx_state_t   state;
  tx_state_t   next_state;
  logic        pcs_reset;
  logic        ctrl_reset;
  logic        ctrl_eee;
  logic [8:0]  maint_reg;
  logic [31:0] block_count;
  logic [31:0] frame_count;
  logic [79:0] octet_buf;
  logic [9:0]  ctrl_buf;
  logic [3:0]  octet_idx;
  logic [5:0]  block_idx;
  logic        lpi_req;
  logic        octet_is_ctrl;
  logic [2:0]  octet_code;
  logic [7:0]  octet_val;
  logic [79:0] full_td;
  logic [9:0]  full_tc;
  logic        coding;
  logic        sym_step;
  logic [1:0]  sym_cnt;
  symbol_t     train_symbol;
  logic        train_info;
  logic        field_sym;
  logic        wb_req;
  logic [31:0] rd_data;

  // ****************************************
  // reset flag
  // ****************************************
  // power-on forces the flag; afterwards it follows the management bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pcs_reset <= 1'b1;
    end else begin
      pcs_reset <= ctrl_reset;
    end
  end

  // ****************************************
  // transmit mode machine
  // ****************************************
  assign lpi_req = !gmii_tx.tx_en && gmii_tx.tx_er
                   && (gmii_tx.txd == `LPI_REQ_TXD);

  always_comb begin
    next_state = state;
    case (state)
      ST_RESET: next_state = ST_TRAIN;
      ST_TRAIN: begin
        if (pma_transmit_mode_indication) begin
          next_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (!pma_transmit_mode_indication) begin
          next_state = ST_TRAIN;
        end else if (ctrl_eee && lpi_req) begin
          next_state = ST_LPI;
        end
      end
      ST_LPI: begin
        if (!pma_transmit_mode_indication) begin
          next_state = ST_TRAIN;
        end else if (!lpi_req) begin
          next_state = ST_DATA; // idle octets bring the link back
        end
      end
      default: next_state = ST_RESET;
    endcase
  end

  // the mode machine parks in its reset state while the flag stands
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_RESET;
    end else if (pcs_reset) begin
      state <= ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign coding        = (state == ST_DATA) || (state == ST_LPI);
  assign tx_lpi_active = (state == ST_LPI);

  // ****************************************
  // octet classification
  // ****************************************
  // only supported codes can come out of this mux
  always_comb begin
    octet_is_ctrl = 1'b1;
    octet_code    = loc_data_ready ? `CODE_IDLE_READY : `CODE_IDLE_NREADY;
    if (gmii_tx.tx_en && gmii_tx.tx_er) begin
      octet_code = `CODE_TX_ERROR;
    end else if (gmii_tx.tx_en) begin
      octet_is_ctrl = 1'b0;
    end else if (lpi_req && ctrl_eee) begin
      octet_code = `CODE_LPI;
    end
    // without support the request falls through to idle
    octet_val = octet_is_ctrl ? control_octet(octet_code) : gmii_tx.txd;
  end

  // ****************************************
  // ten-octet gathering
  // ****************************************
  // the tenth octet joins the buffer in the same cycle it is encoded
  always_comb begin
    full_td = octet_buf;
    full_tc = ctrl_buf;
    full_td[8*octet_idx +: 8] = octet_val;
    full_tc[octet_idx]        = octet_is_ctrl;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      octet_buf <= 80'h0;
      ctrl_buf  <= 10'h000;
      octet_idx <= 4'h0;
    end else if (!coding) begin
      octet_idx <= 4'h0; // blocks align to the first data-mode octet
    end else begin
      octet_buf <= full_td;
      ctrl_buf  <= full_tc;
      if (octet_idx == `OCTETS_PER_BLOCK - 4'h1) begin
        octet_idx <= 4'h0;
      end else begin
        octet_idx <= octet_idx + 4'h1;
      end
    end
  end

  // ****************************************
  // block and frame output
  // ****************************************
  // block bit zero is bits[0] and goes out first
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      coded_block <= '0;
      block_valid <= 1'b0;
      block_idx   <= 6'h00;
    end else begin
      block_valid <= 1'b0;
      if (!coding) begin
        block_idx <= 6'h00;
      end else if (octet_idx == `OCTETS_PER_BLOCK - 4'h1) begin
        coded_block.bits  <= encode_block(full_td, full_tc);
        coded_block.index <= block_idx;
        block_valid       <= 1'b1;
        if (block_idx == `BLOCKS_PER_FRAME - 6'h01) begin
          block_idx <= 6'h00;
        end else begin
          block_idx <= block_idx + 6'h01;
        end
      end
    end
  end

  // one maintenance symbol closes each group of 45 blocks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      maintenance_symbol <= `MAINT_RESET_VAL;
      maintenance_valid  <= 1'b0;
    end else begin
      maintenance_valid <= block_valid
                           && (coded_block.index == `BLOCKS_PER_FRAME - 6'h01);
      maintenance_symbol <= maint_reg;
    end
  end

  // counters visible to software
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      block_count <= 32'h0000_0000;
      frame_count <= 32'h0000_0000;
    end else if (pcs_reset) begin
      block_count <= 32'h0000_0000;
      frame_count <= 32'h0000_0000;
    end else begin
      if (block_valid) begin
        block_count <= block_count + 32'h0000_0001;
      end
      if (maintenance_valid) begin
        frame_count <= frame_count + 32'h0000_0001;
      end
    end
  end

  // ****************************************
  // symbol path
  // ****************************************
  // a period shorter than the clock still gives one symbol per cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sym_cnt <= 2'h0;
    end else if (sym_cnt == 2'(`SYM_CYCLES - 1)) begin
      sym_cnt <= 2'h0;
    end else begin
      sym_cnt <= sym_cnt + 2'h1;
    end
  end

  assign sym_step = (sym_cnt == 2'(`SYM_CYCLES - 1)) && (state == ST_TRAIN);

  training_sequence_gen u_train (
    .sys_clk         (sys_clk),
    .rst_n           (rst_n),
    .clear           (state != ST_TRAIN),
    .step            (sym_step),
    .loc_rcvr_status (loc_rcvr_status),
    .symbol          (train_symbol),
    .info_active     (train_info)
  );

  // training symbols go straight out; data mode hands blocks downstream
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pma_symbol                  <= SYM_ZERO;
      pma_symbol_transfer_request <= 1'b0;
      startup_information_field   <= 1'b0;
      field_sym                   <= 1'b0;
    end else begin
      pma_symbol_transfer_request <= sym_step;
      startup_information_field   <= sym_step && field_sym;
      if (sym_step) begin
        field_sym <= train_info; // symbol register lags the field flag by one step
      end
      pma_symbol                  <= (state == ST_TRAIN) ? train_symbol : SYM_ZERO;
    end
  end

  // ****************************************
  // register bus
  // ****************************************
  assign wb_req = wb_cyc_i && wb_stb_i;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o;
    end
  end

  // writes land at the ack edge; unmapped writes are dropped
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reset <= 1'b0;
      ctrl_eee   <= 1'b0;
      maint_reg  <= `MAINT_RESET_VAL;
    end else if (wb_req && wb_we_i && wb_ack_o) begin
      if (wb_adr_i == `REG_CTRL && wb_sel_i[0]) begin
        ctrl_reset <= wb_dat_i[`CTRL_RESET_BIT];
        ctrl_eee   <= wb_dat_i[`CTRL_EEE_BIT];
      end
      if (wb_adr_i == `REG_MAINT) begin
        if (wb_sel_i[0]) begin
          maint_reg[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          maint_reg[8] <= wb_dat_i[8];
        end
      end
    end
  end

  always_comb begin
    case (wb_adr_i)
      `REG_CTRL:        rd_data = {30'h0, ctrl_eee, ctrl_reset};
      `REG_STATUS:      rd_data = {27'h0, loc_rcvr_status, tx_lpi_active,
                                   state == ST_DATA, state == ST_TRAIN, pcs_reset};
      `REG_BLOCK_COUNT: rd_data = block_count;
      `REG_MAINT:       rd_data = {23'h0, maint_reg};
      `REG_FRAME_COUNT: rd_data = frame_count;
      default:          rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_ack_o) begin
      wb_dat_o <= rd_data;
    end
  end

endmodule : pcs_81b_block_transmit_encoder
`default_nettype wire

// ### sim/pcs_81b_block_transmit_encoder_assertions.sv
// Purpose: concurrent checks on the 81-bit block transmit encoder ports
// Assumes: single clock domain, asynchronous active-low reset
// Notes:   bound to the top module at the foot of this file
`default_nettype none
module pcs_tx_checker
  import pcs_tx_pkg::*;
(
  input wire logic                     sys_clk,
  input wire logic                     rst_n,
  input wire logic                     wb_cyc_i,
  input wire logic                     wb_stb_i,
  input wire logic                     wb_ack_o,
  input wire pcs_tx_pkg::gmii_tx_t     gmii_tx,
  input wire pcs_tx_pkg::coded_block_t coded_block,
  input wire logic                     block_valid,
  input wire logic                     maintenance_valid,
  input wire pcs_tx_pkg::symbol_t      pma_symbol,
  input wire logic                     pma_symbol_transfer_request,
  input wire logic                     startup_information_field,
  input wire logic                     tx_lpi_active
);
  import pcs_tx_pkg::*;
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // reset must silence outputs, so no disable here
  property p_reset_quiet;
    disable iff (1'h0) !rst_n |-> !block_valid && !wb_ack_o && !pma_symbol_transfer_request;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("output active in reset");
  property p_train_levels;
    pma_symbol_transfer_request |-> pma_symbol inside {SYM_PLUS, SYM_MINUS};
  endproperty
  a_train_levels: assert property (p_train_levels) else $error("training level bad");
  property p_field_train;
    startup_information_field |-> pma_symbol_transfer_request;
  endproperty
  a_field_train: assert property (p_field_train) else $error("field outside training");
  property p_block_gap;
    block_valid |=> !block_valid [*8];
  endproperty
  a_block_gap: assert property (p_block_gap) else $error("blocks too close");
  // a block ten cycles on carries the next index, wrapping after 44
  property p_index_step;
    block_valid |-> ##10 (!block_valid || coded_block.index ==
      (($past(coded_block.index, 10) == 6'h2C) ? 6'h00 : $past(coded_block.index, 10) + 6'h01));
  endproperty
  a_index_step: assert property (p_index_step) else $error("block index step wrong");
  property p_maint_after;
    block_valid && coded_block.index == 6'h2C |=> maintenance_valid;
  endproperty
  a_maint_after: assert property (p_maint_after) else $error("maintenance missing");
  property p_maint_cause;
    maintenance_valid |-> $past(block_valid) && $past(coded_block.index) == 6'h2C;
  endproperty
  a_maint_cause: assert property (p_maint_cause) else $error("maintenance stray");
  property p_lpi_entry;
    $rose(tx_lpi_active) |-> $past(gmii_tx) == {8'h01, 2'h1};
  endproperty
  a_lpi_entry: assert property (p_lpi_entry) else $error("low-power idle uncaused");
  property p_lpi_exit;
    tx_lpi_active && gmii_tx != {8'h01, 2'h1} |=> !tx_lpi_active;
  endproperty
  a_lpi_exit: assert property (p_lpi_exit) else $error("low-power idle not left");
  property p_ack_pulse;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("bus answer wrong");
  c_ctrl_block: cover property (block_valid && coded_block.bits[0]);
  c_maint: cover property (maintenance_valid);
  c_lpi: cover property ($rose(tx_lpi_active));
  c_field: cover property ($rose(startup_information_field));
endmodule : pcs_tx_checker
bind pcs_81b_block_transmit_encoder pcs_tx_checker u_pcs_tx_checker (.sys_clk, .rst_n,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .gmii_tx, .coded_block, .block_valid, .maintenance_valid,
  .pma_symbol, .pma_symbol_transfer_request, .startup_information_field, .tx_lpi_active);
`default_nettype wire

// ### sim/mac_octet_source.sv
// Purpose: transmit-side client model feeding one octet per clock
// Assumes: mode chosen by the bench
// Notes:   0 mixed, 1 idle, 2 low-power request, 3 data only
`default_nettype none
module mac_octet_source
  import pcs_tx_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic [1:0]      mode,
  output var pcs_tx_pkg::gmii_tx_t gmii_tx
);
  import pcs_tx_pkg::*;
  logic [7:0] rnd;
  logic       ctl;
  initial gmii_tx = '0;
  // ****************************************
  // octet source
  // ****************************************
  // changes right after the edge; control kept rare so all-data blocks occur
  always @(posedge sys_clk) begin
    rnd = 8'($urandom);
    ctl = ($urandom % 8) == 0;
    case (mode)
      2'h0: gmii_tx <= {rnd, !ctl || rnd[0], ctl && rnd[0]};
      2'h1: gmii_tx <= {rnd, 2'h0};
      2'h2: gmii_tx <= {8'h01, 2'h1};
      default: gmii_tx <= {rnd, 2'h2};
    endcase
  end
endmodule : mac_octet_source
`default_nettype wire

// ### sim/pcs_81b_block_transmit_encoder_tb.sv
// Purpose: self-checking bench of the 81-bit block transmit encoder
// Assumes: fixed seed, one 10 MHz clock
// Notes:   each block is rebuilt from the octets seen at the pins
`include "pcs_tx_consts.svh"
`default_nettype none
module pcs_81b_block_transmit_encoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pcs_tx_pkg::*;
  logic         sys_clk, rst_n, wb_we_i, wb_cyc_i, wb_stb_i, block_valid, maintenance_valid;
  logic [7:0]   wb_adr_i;
  logic [31:0]  wb_dat_i, wb_dat_o, rd;
  logic [3:0]   wb_sel_i;
  logic         wb_ack_o, pma_transmit_mode_indication, loc_rcvr_status, loc_data_ready;
  logic         pma_symbol_transfer_request, startup_information_field, tx_lpi_active, eee;
  logic [8:0]   maintenance_symbol, mval;
  logic [1:0]   mode;
  logic [15:0]  field;
  logic [8:0]   hist [$];
  logic [8:0]   oc [10];
  gmii_tx_t     gmii_tx;
  coded_block_t coded_block;
  symbol_t      pma_symbol;
  int           num_errors, check_count, cycles, n_blocks, n_maint, n, n0;

  pcs_81b_block_transmit_encoder u_pcs_81b_block_transmit_encoder (.sys_clk, .rst_n,
    .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
    .gmii_tx, .pma_transmit_mode_indication, .loc_rcvr_status, .loc_data_ready, .coded_block,
    .block_valid, .maintenance_symbol, .maintenance_valid, .pma_symbol,
    .pma_symbol_transfer_request, .startup_information_field, .tx_lpi_active);
  mac_octet_source u_mac_octet_source (.sys_clk, .mode, .gmii_tx);

  // ****************************************
  // expectations
  // ****************************************
  // returns {control flag, octet as placed in the block}
  function automatic logic [8:0] octet_of(gmii_tx_t o, logic rdy, logic lp);
    if (o.tx_en) return o.tx_er ? {1'h1, `CODE_TX_ERROR, 5'h00} : {1'h0, o.txd};
    if (lp && o.tx_er && o.txd == `LPI_REQ_TXD) return {1'h1, `CODE_LPI, 5'h00};
    return {1'h1, rdy ? `CODE_IDLE_READY : `CODE_IDLE_NREADY, 5'h00};
  endfunction : octet_of

  function automatic logic [80:0] encode(logic [8:0] o [10]);
    logic [80:0] b;
    logic        any;
    int          cnt;
    int          nxt;
    b = '0;
    for (int i = 0; i < 10; i++) begin
      any = 1'h0;
      cnt = 0;
      nxt = 0;
      for (int m = 9; m >= i; m--) begin
        if (o[m][8]) begin
          any = 1'h1;
          cnt++;
          nxt = m;
        end
      end
      if (i == 0) b[0] = any;
      if (!any) b[8*i+1 +: 8] = o[i][7:0];
      else begin
        b[8*i+1 +: 5] = (i == 0 || o[i-1][8]) ? {cnt != 1, 4'(nxt)} : o[i-1][7:3];
        b[8*i+6 +: 3] = o[i][8] ? o[i][7:5] : o[i][2:0];
      end
    end
    return b;
  endfunction : encode

  task automatic check(string what, logic [80:0] seen, logic [80:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // classic cycle: hold everything until ack is sampled, then release
  task automatic wb(logic we, logic [7:0] adr, logic [31:0] dat);
    @(posedge sys_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i  <= 1'h0;
  endtask : wb

  task automatic run(logic [1:0] m, int c);
    mode <= m;
    repeat (c) @(posedge sys_clk);
  endtask : run

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  // ****************************************
  // monitor, clock and sequence
  // ****************************************
  // block seen now was built from the octets of edges 10 to 1 back
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      num_errors++;
      test_done();
    end
    if (maintenance_valid === 1'h1) n_maint++;
    if (!rst_n) hist.delete();
    else begin
      hist.push_back(octet_of(gmii_tx, loc_data_ready, eee));
      if (hist.size() > 12) void'(hist.pop_front());
      if (block_valid === 1'h1 && hist.size() == 12) begin
        n_blocks++;
        for (int i = 0; i < 10; i++) oc[i] = hist[i+1];
        check("coded_block", coded_block.bits, encode(oc));
      end
    end
  end

  always #50 sys_clk = ~sys_clk;

  initial begin
    void'($urandom(32'h79034484));
    {sys_clk, rst_n, wb_we_i, wb_cyc_i, wb_stb_i, eee, pma_transmit_mode_indication} = '0;
    {wb_adr_i, wb_dat_i, mode} = '0;
    wb_sel_i = 4'hF;
    loc_rcvr_status = 1'h1;
    loc_data_ready = 1'h1;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'h1;
    wb(1'h0, `REG_CTRL, 32'h0);
    check("ctrl", rd, `CTRL_RESET_VAL);
    wb(1'h0, `REG_MAINT, 32'h0);
    check("maint", rd, 32'(`MAINT_RESET_VAL));
    mval = 9'($urandom);
    wb(1'h1, `REG_MAINT, {23'h7FFFFF, mval});
    wb(1'h0, `REG_MAINT, 32'h0);
    check("maint", rd, 32'(mval));
    check("maint_port", maintenance_symbol, mval);
    wb(1'h1, 8'h40, 32'hFFFFFFFF);
    wb(1'h0, 8'h40, 32'h0);
    check("unmapped", rd, 32'h0);
    wb(1'h0, `REG_STATUS, 32'h0);
    check("status", rd[4:0], 5'h12);
    // startup field, skipping one already under way
    loc_rcvr_status <= 1'($urandom);
    while (startup_information_field === 1'h1) @(posedge sys_clk);
    n = 0;
    while (startup_information_field !== 1'h1 && n < 1200) begin
      @(posedge sys_clk);
      n++;
    end
    field = {loc_rcvr_status, `INFO_HEADER};
    for (int i = 0; i < 16; i++) begin
      check("field_sym", pma_symbol, field[i] ? SYM_PLUS : SYM_MINUS);
      @(posedge sys_clk);
    end
    pma_transmit_mode_indication <= 1'h1;
    run(2'h0, 480);
    run(2'h1, 30);
    run(2'h3, 30);
    loc_data_ready <= 1'h0;
    run(2'h3, 5);
    run(2'h1, 30);
    loc_data_ready <= 1'h1;
    run(2'h2, 30);
    check("lpi_off", tx_lpi_active, 1'h0);
    run(2'h1, 5);
    wb(1'h1, `REG_CTRL, 32'h2);
    eee <= 1'h1;
    run(2'h2, 30);
    check("lpi_on", tx_lpi_active, 1'h1);
    run(2'h1, 5);
    check("lpi_left", tx_lpi_active, 1'h0);
    wb(1'h1, `REG_CTRL, 32'h3);
    wb(1'h0, `REG_STATUS, 32'h0);
    check("pcs_reset", rd[0], 1'h1);
    @(posedge sys_clk); // a block launched at the reset edge is counted first
    n0 = n_blocks;
    run(2'h0, 30);
    check("held", n_blocks, n0);
    wb(1'h1, `REG_CTRL, 32'h2);
    run(2'h0, 100);
    check("resumed", n_blocks > n0 + 5, 1'h1);
    check("maint_seen", n_maint > 0, 1'h1);
    test_done();
  end
endmodule : pcs_81b_block_transmit_encoder_tb
`default_nettype wire
